// >>> rof_bit_mux.v
// one selector: picks one source bit by its code
// assumes the caller zeroes every source position with no function
`timescale 1ns/1ps
`include "rof_selector_regs.vh"
module rof_bit_mux (
  input wire [`ROF_SRC_W-1:0] src,
  input wire [`ROF_CODE_W-1:0] code,
  output wire bit_out
);

  // ---------------------------------------------------------------
  // codes above the source range read zero
  // ---------------------------------------------------------------
  assign bit_out = code[`ROF_CODE_W-1] ? 1'b0 :
    src[code[`ROF_CODE_W-2:0]];
endmodule

// >>> rof_host_model.sv
// host model: polls the remote output word like a network host
// assumes poll is a one-cycle strobe on the design clock
`timescale 1ns/1ps
module rof_host_model (
  input wire clk,
  input wire poll,
  input wire [15:0] bits,
  output reg [15:0] seen
);
  always @(posedge clk) begin
    if (poll)
      seen <= bits;
  end
endmodule

// >>> rof_selector.v
// remote output selector: sixteen remote output bits, each picking an
// internal status or echoed input by a software selector code
// assumes avalon-mm master on CLK, pin inputs asynchronous, others
// from logic on CLK
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rof_selector_regs.vh"

module rof_selector #(
  parameter AC_VARIANT = 1
) (
  input wire CLK,
  input wire RESET,
  input wire [`ROF_ADDR_W-1:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output wire IRQ,
  input wire FORWARD_RUN_IN,
  input wire REVERSE_RUN_IN,
  input wire HOMING_RUN_IN,
  input wire START_RUN_IN,
  input wire SEQUENCE_LAUNCH_IN,
  input wire PLUS_INCH_IN,
  input wire MINUS_INCH_IN,
  input wire [5:0] DIRECT_LAUNCH_IN,
  input wire RELEASE_IN,
  input wire CURRENT_ON_IN,
  input wire STOP_IN,
  input wire [5:0] DATA_SEL_IN,
  input wire POSITIVE_LIMIT_PIN,
  input wire NEGATIVE_LIMIT_PIN,
  input wire ORIGIN_SENSOR_PIN,
  input wire SLOT_SENSOR_PIN,
  input wire MAIN_SUPPLY_PIN,
  input wire ALARM_ACTIVE,
  input wire WARNING_ACTIVE,
  input wire DRIVER_READY,
  input wire MOTOR_MOVING,
  input wire POSITIONING_DONE,
  input wire AT_HOME,
  input wire TORQUE_LIMIT_EXCEEDED,
  input wire SHAFT_STEP_PULSE,
  input wire [2:0] ZONE_FLAG,
  input wire INTERNAL_PROCESSING_FLAG,
  output reg [`ROF_NBITS-1:0] REMOTE_OUTPUT_BIT
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam [8*`ROF_NBITS-1:0] SEL_RESET = `ROF_SEL_RESET;

  reg [`ROF_CODE_W-1:0] sel_q [0:`ROF_NBITS-1];
  reg [`ROF_NBITS-1:0] flags_q;
  reg [`ROF_NBITS-1:0] irq_status_q;
  reg [`ROF_NBITS-1:0] irq_mask_q;
  reg [`ROF_NBITS-1:0] irq_status_d;
  reg ack_q;
  reg [31:0] rdata_d;
  wire [`ROF_SYNC_W-1:0] pins_raw;
  wire [`ROF_SYNC_W-1:0] pins_sync;
  wire [`ROF_SRC_W-1:0] src;
  wire [`ROF_NBITS-1:0] out_d;
  wire [`ROF_NBITS-1:0] rise;
  wire req;
  wire wr_go;
  wire [4:0] word;
  wire sel_hit;
  wire [3:0] sel_idx;
  wire [4:0] sel_off;
  wire [31:0] be_mask;
  integer i;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pins_raw = {MAIN_SUPPLY_PIN, SLOT_SENSOR_PIN, ORIGIN_SENSOR_PIN,
    NEGATIVE_LIMIT_PIN, POSITIVE_LIMIT_PIN};

  rof_sync u_sync (
    .clk(CLK),
    .rst(RESET),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // ---------------------------------------------------------------
  // source vector indexed by selector code
  // ---------------------------------------------------------------
  assign src[`ROF_CODE_NONE] = 1'b0;
  assign src[`ROF_CODE_FWD] = FORWARD_RUN_IN;
  assign src[`ROF_CODE_REV] = REVERSE_RUN_IN;
  assign src[`ROF_CODE_HOMING] = HOMING_RUN_IN;
  assign src[`ROF_CODE_START] = START_RUN_IN;
  assign src[`ROF_CODE_SEQ] = SEQUENCE_LAUNCH_IN;
  assign src[`ROF_CODE_PINCH] = PLUS_INCH_IN;
  assign src[`ROF_CODE_MINCH] = MINUS_INCH_IN;
  assign src[`ROF_CODE_DLAUNCH0+5:`ROF_CODE_DLAUNCH0] =
    DIRECT_LAUNCH_IN;
  assign src[`ROF_CODE_RELEASE-1:`ROF_CODE_DLAUNCH0+6] = 2'b00;
  assign src[`ROF_CODE_RELEASE] = RELEASE_IN;
  assign src[`ROF_CODE_CURON] = CURRENT_ON_IN;
  assign src[`ROF_CODE_STOP] = STOP_IN;
  assign src[`ROF_CODE_FLAG0-1:`ROF_CODE_STOP+1] = 13'h0000;
  assign src[`ROF_CODE_FLAG0+15:`ROF_CODE_FLAG0] = flags_q;
  assign src[`ROF_CODE_DSEL0+5:`ROF_CODE_DSEL0] = DATA_SEL_IN;
  assign src[`ROF_CODE_PLIM-1:`ROF_CODE_DSEL0+6] = 6'h00;
  assign src[`ROF_CODE_PLIM] = pins_sync[0];
  assign src[`ROF_CODE_NLIM] = pins_sync[1];
  assign src[`ROF_CODE_ORIGIN] = pins_sync[2];
  assign src[`ROF_CODE_SLOT] = pins_sync[3];
  assign src[`ROF_CODE_ALARM-1] = 1'b0;
  assign src[`ROF_CODE_ALARM] = ALARM_ACTIVE;
  assign src[`ROF_CODE_WARN] = WARNING_ACTIVE;
  assign src[`ROF_CODE_READY] = DRIVER_READY;
  assign src[`ROF_CODE_MOVE] = MOTOR_MOVING;
  assign src[`ROF_CODE_DONE] = POSITIONING_DONE;
  assign src[`ROF_CODE_ATHOME] = AT_HOME;
  assign src[`ROF_CODE_TORQUE] = TORQUE_LIMIT_EXCEEDED;
  assign src[`ROF_CODE_STEP] = SHAFT_STEP_PULSE;
  assign src[`ROF_CODE_ZONE1+2:`ROF_CODE_ZONE1] = ZONE_FLAG;
  assign src[`ROF_CODE_BUSY-1:`ROF_CODE_ZONE1+3] = 4'h0;
  assign src[`ROF_CODE_BUSY] = INTERNAL_PROCESSING_FLAG;
  assign src[`ROF_CODE_BUSY+1] = 1'b0;
  assign src[`ROF_CODE_SUPPLY] = (AC_VARIANT != 0) ?
    pins_sync[4] : 1'b0;
  assign src[`ROF_SRC_W-1:`ROF_CODE_SUPPLY+1] = 45'h0;

  // ---------------------------------------------------------------
  // one selector per output bit
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `ROF_NBITS; g = g + 1) begin : gen_bit
      rof_bit_mux u_mux (
        .src(src),
        .code(sel_q[g]),
        .bit_out(out_d[g])
      );
    end
  endgenerate

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      REMOTE_OUTPUT_BIT <= `ROF_ZERO16;
    end else begin
      REMOTE_OUTPUT_BIT <= out_d;
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave: one wait state per access
  // ---------------------------------------------------------------
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_go = AVS_WRITE & ack_q;
  assign word = AVS_ADDRESS[`ROF_ADDR_W-1:2];
  assign sel_hit = (word >= `ROF_WORD_SEL_FIRST) &&
    (word <= `ROF_WORD_SEL_LAST);
  assign sel_off = word - `ROF_WORD_SEL_FIRST;
  assign sel_idx = sel_off[3:0];
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always @* begin
    rdata_d = `ROF_ZERO32;
    if (sel_hit) begin
      rdata_d = {24'h000000, sel_q[sel_idx]};
    end else begin
      case (AVS_ADDRESS & 7'h7c)
        `ROF_OFS_OUT_STATUS: rdata_d = {16'h0000, REMOTE_OUTPUT_BIT};
        `ROF_OFS_GP_FLAGS: rdata_d = {16'h0000, flags_q};
        `ROF_OFS_IRQ_STATUS: rdata_d = {16'h0000, irq_status_q};
        `ROF_OFS_IRQ_MASK: rdata_d = {16'h0000, irq_mask_q};
        default: rdata_d = `ROF_ZERO32;
      endcase
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
      AVS_READDATA <= `ROF_ZERO32;
    end else begin
      ack_q <= req & ~ack_q;
      if (AVS_READ & ~ack_q) begin
        AVS_READDATA <= rdata_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (i = 0; i < `ROF_NBITS; i = i + 1) begin
        sel_q[i] <= SEL_RESET[8*i +: 8];
      end
      flags_q <= `ROF_ZERO16;
      irq_mask_q <= `ROF_ZERO16;
    end else if (wr_go) begin
      if (sel_hit && AVS_BYTEENABLE[0]) begin
        sel_q[sel_idx] <= AVS_WRITEDATA[7:0];
      end
      if ((AVS_ADDRESS & 7'h7c) == `ROF_OFS_GP_FLAGS) begin
        flags_q <= (flags_q & ~be_mask[15:0]) |
          (AVS_WRITEDATA[15:0] & be_mask[15:0]);
      end
      if ((AVS_ADDRESS & 7'h7c) == `ROF_OFS_IRQ_MASK) begin
        irq_mask_q <= (irq_mask_q & ~be_mask[15:0]) |
          (AVS_WRITEDATA[15:0] & be_mask[15:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts: rising output bit sets sticky status
  // ---------------------------------------------------------------
  assign rise = out_d & ~REMOTE_OUTPUT_BIT;

  always @* begin
    irq_status_d = irq_status_q;
    if (wr_go && ((AVS_ADDRESS & 7'h7c) == `ROF_OFS_IRQ_STATUS)) begin
      irq_status_d = irq_status_q & ~(AVS_WRITEDATA[15:0] & be_mask[15:0]);
    end
    irq_status_d = irq_status_d | rise;
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_status_q <= `ROF_ZERO16;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  assign IRQ = |(irq_status_q & irq_mask_q);
endmodule

// >>> rof_selector_monitor.sv
// checker of the remote output selector, watching output bit 0
// assumes a bind to rof_selector, sees only its ports
`timescale 1ns/1ps
module rof_selector_monitor (
  input wire CLK,
  input wire RESET,
  input wire [6:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire AVS_WAITREQUEST,
  input wire FORWARD_RUN_IN,
  input wire STOP_IN,
  input wire [5:0] DATA_SEL_IN,
  input wire POSITIVE_LIMIT_PIN,
  input wire ALARM_ACTIVE,
  input wire POSITIONING_DONE,
  input wire [15:0] REMOTE_OUTPUT_BIT
);
  // ----
  // shadow of selector 0 and flags
  // ----
  reg [7:0] sel_q;
  reg [15:0] flag_q;
  reg [1:0] age_q;
  wire out0 = REMOTE_OUTPUT_BIT[0];
  wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire flag_pick = flag_q[sel_q[3:0]];
  wire dsel_pick = DATA_SEL_IN[sel_q[2:0]];
  wire unused = sel_q == 8'h00 || sel_q == 8'h0e || sel_q == 8'h40 ||
    sel_q == 8'h51 || sel_q[7];
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel_q <= 8'h30;
      flag_q <= 16'h0000;
      age_q <= 2'h0;
    end else begin
      if (age_q != 2'h3)
        age_q <= age_q + 2'h1;
      if (wr_ok && AVS_ADDRESS[6:2] == 5'h04)
        sel_q <= AVS_WRITEDATA[7:0];
      if (wr_ok && AVS_ADDRESS[6:2] == 5'h01)
        flag_q <= AVS_WRITEDATA[15:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("long wait");
  AST_FWD: assert property (age_q != 2'h0 &&
    $past(sel_q) == 8'h01 |-> out0 == $past(FORWARD_RUN_IN))
    else $error("forward echo wrong");
  AST_STOP: assert property (sel_q == 8'h12 &&
    $rose(STOP_IN) |=> out0) else $error("stop echo late");
  AST_FLAG: assert property (age_q != 2'h0 &&
    $past(sel_q) inside {[8'h20:8'h2f]} |-> out0 == $past(flag_pick))
    else $error("flag bit wrong");
  AST_DSEL: assert property (age_q != 2'h0 &&
    $past(sel_q) inside {[8'h30:8'h35]} |-> out0 == $past(dsel_pick))
    else $error("data select echo wrong");
  AST_SENSOR: assert property (age_q == 2'h3 &&
    $past(sel_q) == 8'h3c |-> out0 == $past(POSITIVE_LIMIT_PIN, 3))
    else $error("limit sensor echo wrong");
  AST_ALARM: assert property (age_q != 2'h0 &&
    $past(sel_q) == 8'h41 |-> out0 == $past(ALARM_ACTIVE))
    else $error("alarm wrong");
  AST_DONE: assert property (age_q != 2'h0 &&
    $past(sel_q) == 8'h45 |-> out0 == $past(POSITIONING_DONE))
    else $error("done wrong");
  AST_UNUSED: assert property (age_q != 2'h0 &&
    $past(unused) |-> !out0) else $error("unused bit not zero");
endmodule
bind rof_selector rof_selector_monitor i_rof_selector_monitor (
  .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .FORWARD_RUN_IN(FORWARD_RUN_IN),
  .STOP_IN(STOP_IN), .DATA_SEL_IN(DATA_SEL_IN),
  .POSITIVE_LIMIT_PIN(POSITIVE_LIMIT_PIN), .ALARM_ACTIVE(ALARM_ACTIVE),
  .POSITIONING_DONE(POSITIONING_DONE),
  .REMOTE_OUTPUT_BIT(REMOTE_OUTPUT_BIT)
);

// >>> rof_selector_regs.vh
// register map, selector codes and reset values of the remote output
// selector; assumes a 32-bit avalon-mm slave with byte addressing
`ifndef ROF_SELECTOR_REGS_VH
`define ROF_SELECTOR_REGS_VH

// ---------------------------------------------------------------
// register byte offsets, and the word index range of the selectors
// ---------------------------------------------------------------
`define ROF_ADDR_W 7
`define ROF_OFS_OUT_STATUS 7'h00
`define ROF_OFS_GP_FLAGS 7'h04
`define ROF_OFS_IRQ_STATUS 7'h08
`define ROF_OFS_IRQ_MASK 7'h0c
`define ROF_WORD_SEL_FIRST 5'h04
`define ROF_WORD_SEL_LAST 5'h13

// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define ROF_NBITS 16
`define ROF_CODE_W 8
`define ROF_SRC_W 128
`define ROF_SYNC_W 5

// ---------------------------------------------------------------
// selector codes
// ---------------------------------------------------------------
`define ROF_CODE_NONE 0
`define ROF_CODE_FWD 1
`define ROF_CODE_REV 2
`define ROF_CODE_HOMING 3
`define ROF_CODE_START 4
`define ROF_CODE_SEQ 5
`define ROF_CODE_PINCH 6
`define ROF_CODE_MINCH 7
`define ROF_CODE_DLAUNCH0 8
`define ROF_CODE_RELEASE 16
`define ROF_CODE_CURON 17
`define ROF_CODE_STOP 18
`define ROF_CODE_FLAG0 32
`define ROF_CODE_DSEL0 48
`define ROF_CODE_PLIM 60
`define ROF_CODE_NLIM 61
`define ROF_CODE_ORIGIN 62
`define ROF_CODE_SLOT 63
`define ROF_CODE_ALARM 65
`define ROF_CODE_WARN 66
`define ROF_CODE_READY 67
`define ROF_CODE_MOVE 68
`define ROF_CODE_DONE 69
`define ROF_CODE_ATHOME 70
`define ROF_CODE_TORQUE 71
`define ROF_CODE_STEP 72
`define ROF_CODE_ZONE1 73
`define ROF_CODE_BUSY 80
`define ROF_CODE_SUPPLY 82

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ROF_SEL_RESET {8'h47, 8'h45, 8'h44, 8'h48, 8'h4b, 8'h4a, \
  8'h49, 8'h50, 8'h41, 8'h42, 8'h43, 8'h46, 8'h04, 8'h32, 8'h31, 8'h30}
`define ROF_ZERO16 16'h0000
`define ROF_ZERO32 32'h0000_0000

`endif

// >>> rof_sync.v
// two-flop synchroniser for pin inputs of the remote output selector
// assumes a single clock with asynchronous active-high reset
`timescale 1ns/1ps
`include "rof_selector_regs.vh"
module rof_sync (
  input wire clk,
  input wire rst,
  input wire [`ROF_SYNC_W-1:0] async_in,
  output reg [`ROF_SYNC_W-1:0] sync_out
);

  reg [`ROF_SYNC_W-1:0] meta_q;

  // ---------------------------------------------------------------
  // first stage read only by the second
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {`ROF_SYNC_W{1'b0}};
      sync_out <= {`ROF_SYNC_W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> tb_rof_selector.sv
// bench of the remote output selector
// assumes the design, its header, host model and monitor
`timescale 1ns/1ps
`include "rof_selector_regs.vh"
module tb_rof_selector;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [6:0] adr = 7'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [127:0] src = 128'h0;
  reg poll = 1'b0;
  wire [31:0] rdat;
  wire wait_req;
  wire irq;
  wire [15:0] rob;
  wire [15:0] seen;
  integer failures = 0;
  integer checks = 0;
  always #2 clk = ~clk;
  rof_selector i_rof_selector (
    .CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .IRQ(irq),
    .FORWARD_RUN_IN(src[1]), .REVERSE_RUN_IN(src[2]),
    .HOMING_RUN_IN(src[3]), .START_RUN_IN(src[4]),
    .SEQUENCE_LAUNCH_IN(src[5]), .PLUS_INCH_IN(src[6]),
    .MINUS_INCH_IN(src[7]), .DIRECT_LAUNCH_IN(src[13:8]),
    .RELEASE_IN(src[16]), .CURRENT_ON_IN(src[17]), .STOP_IN(src[18]),
    .DATA_SEL_IN(src[53:48]), .POSITIVE_LIMIT_PIN(src[60]),
    .NEGATIVE_LIMIT_PIN(src[61]), .ORIGIN_SENSOR_PIN(src[62]),
    .SLOT_SENSOR_PIN(src[63]), .MAIN_SUPPLY_PIN(src[82]),
    .ALARM_ACTIVE(src[65]), .WARNING_ACTIVE(src[66]),
    .DRIVER_READY(src[67]), .MOTOR_MOVING(src[68]),
    .POSITIONING_DONE(src[69]), .AT_HOME(src[70]),
    .TORQUE_LIMIT_EXCEEDED(src[71]), .SHAFT_STEP_PULSE(src[72]),
    .ZONE_FLAG(src[75:73]), .INTERNAL_PROCESSING_FLAG(src[80]),
    .REMOTE_OUTPUT_BIT(rob)
  );
  rof_host_model i_rof_host_model (
    .clk(clk), .poll(poll), .bits(rob), .seen(seen)
  );
  // ----
  // shared tasks
  // ----
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      if (failures == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task bus(input w, input [6:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (wait_req !== 1'b0 && n < 50);
      q = rdat;
      if (wait_req !== 1'b0)
        chk("waitrequest", wait_req, 32'h0);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task look(output [15:0] v);
    begin
      @(posedge clk);
      poll <= 1'b1;
      @(posedge clk);
      poll <= 1'b0;
      @(posedge clk);
      v = seen;
    end
  endtask
  function listed(input integer c);
    begin
      listed = (c >= 1 && c <= 13) || (c >= 16 && c <= 18) ||
        (c >= 32 && c <= 53) || (c >= 60 && c <= 63) ||
        (c >= 65 && c <= 75) || c == 80 || c == 82;
    end
  endfunction
  // ----
  // scenarios
  // ----
  task t_reset;
    integer n;
    reg [31:0] q;
    reg [127:0] rv;
    begin
      rv = `ROF_SEL_RESET;
      for (n = 0; n < 16; n = n + 1) begin
        bus(1'b0, 7'h10 + {n[4:0], 2'h0}, 32'h0, q);
        chk("selector reset", q, rv[n*8 +: 8]);
      end
      bus(1'b1, 7'h7c, 32'hffff_ffff, q);
      bus(1'b0, 7'h7c, 32'h0, q);
      chk("unmapped", q, 32'h0);
    end
  endtask
  task t_all_bits;
    integer n;
    reg [31:0] q;
    reg [15:0] v;
    begin
      for (n = 0; n < 16; n = n + 1)
        bus(1'b1, 7'h10 + {n[4:0], 2'h0}, 32'h20 + n, q);
      bus(1'b1, 7'h04, 32'ha5c3, q);
      look(v);
      chk("all bits", v, 32'ha5c3);
      bus(1'b0, 7'h00, 32'h0, q);
      chk("out status", q, 32'ha5c3);
    end
  endtask
  task t_irq;
    reg [31:0] q;
    begin
      bus(1'b1, 7'h10, 32'h1, q);
      bus(1'b1, 7'h08, 32'hffff, q);
      src <= 128'h2;
      repeat (3) @(posedge clk);
      bus(1'b0, 7'h08, 32'h0, q);
      chk("status set", q, 32'h1);
      chk("irq masked", irq, 32'h0);
      bus(1'b1, 7'h0c, 32'h1, q);
      @(posedge clk);
      chk("irq raised", irq, 32'h1);
      bus(1'b1, 7'h08, 32'h1, q);
      @(posedge clk);
      chk("irq cleared", irq, 32'h0);
    end
  endtask
  task t_codes;
    integer c;
    integer k;
    reg [31:0] q;
    reg [15:0] v;
    reg [127:0] s;
    begin
      for (c = 0; c < 131; c = c + 1) begin
        bus(1'b1, 7'h10, c, q);
        for (k = 1; k >= 0; k = k - 1) begin
          s = (128'h1 << c) ^ {128{k[0]}};
          src <= s;
          bus(1'b1, 7'h04, {16'h0, s[47:32]}, q);
          repeat (4) @(posedge clk);
          look(v);
          chk("code output", v[0], listed(c) && k == 0);
        end
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_all_bits;
    t_irq;
    t_codes;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    finish_test;
  end
endmodule
